// ### design/sensor_regs_pkg.sv
// constants for the sensor window and exposure timing register bank
// assumes byte-wide registers reached over a two-wire serial bus
package sensor_regs_pkg;

	// register byte offsets
	localparam logic [7:0] ADDR_SCAN_ROW_FIRST   = 8'h0B;
	localparam logic [7:0] ADDR_SCAN_ROW_LAST    = 8'h0C;
	localparam logic [7:0] ADDR_HOLE             = 8'h0D;
	localparam logic [7:0] ADDR_VIEW_ROW_FIRST   = 8'h0E;
	localparam logic [7:0] ADDR_VIEW_ROW_LAST    = 8'h0F;
	localparam logic [7:0] ADDR_VIEW_COL_FIRST   = 8'h10;
	localparam logic [7:0] ADDR_VIEW_COL_LAST    = 8'h11;
	localparam logic [7:0] ADDR_WINDOW_LOW_BITS  = 8'h12;
	localparam logic [7:0] ADDR_EXPOSURE_HIGH    = 8'h13;
	localparam logic [7:0] ADDR_EXPOSURE_LOW     = 8'h14;
	localparam logic [7:0] ADDR_LINE_GAP_HIGH    = 8'h15;
	localparam logic [7:0] ADDR_LINE_GAP_LOW     = 8'h16;
	localparam logic [7:0] ADDR_FRAME_GAP_HIGH   = 8'h17;
	localparam logic [7:0] ADDR_FRAME_GAP_LOW    = 8'h18;
	localparam logic [7:0] ADDR_AMPLIFIER_GAIN   = 8'h19;

	// bank index of each register: offset minus the first offset
	localparam int REG_COUNT       = 15;
	localparam int IDX_SCAN_FIRST  = 0;
	localparam int IDX_SCAN_LAST   = 1;
	localparam int IDX_VIEW_RFIRST = 3;
	localparam int IDX_VIEW_RLAST  = 4;
	localparam int IDX_VIEW_CFIRST = 5;
	localparam int IDX_VIEW_CLAST  = 6;
	localparam int IDX_LOW_BITS    = 7;
	localparam int IDX_EXPO_HIGH   = 8;
	localparam int IDX_EXPO_LOW    = 9;
	localparam int IDX_LINE_HIGH   = 10;
	localparam int IDX_LINE_LOW    = 11;
	localparam int IDX_FRAME_HIGH  = 12;
	localparam int IDX_FRAME_LOW   = 13;
	localparam int IDX_GAIN        = 14;

	// values after reset
	localparam logic [7:0] RST_ZERO      = 8'h00;
	localparam logic [7:0] RST_ROW_LAST  = 8'hFB;
	localparam logic [7:0] RST_COL_LAST  = 8'hA5;
	localparam logic [7:0] RST_LOW_BITS  = 8'h32;

	// writable bits; reserved bits are zero here
	localparam logic [7:0] MASK_FULL       = 8'hFF;
	localparam logic [7:0] MASK_NONE       = 8'h00;
	localparam logic [7:0] MASK_LOW_BITS   = 8'h7F;
	localparam logic [7:0] MASK_NIBBLE     = 8'h0F;
	localparam logic [7:0] MASK_LINE_HIGH  = 8'h07;
	localparam logic [7:0] MASK_GAIN       = 8'h3F;

	// field positions in the shared low-bits register
	localparam int BIT_SCAN_INCR       = 6;
	localparam int BIT_VIEW_RFIRST_LSB = 0;
	localparam int BIT_VIEW_RLAST_LSB  = 1;
	localparam int POS_VIEW_CFIRST_LSB = 2;
	localparam int POS_VIEW_CLAST_LSB  = 4;

	// reset and mask tables, index 14 first
	localparam logic [REG_COUNT-1:0][7:0] REG_RESET = {
		RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_LOW_BITS,
		RST_COL_LAST, RST_ZERO, RST_ROW_LAST, RST_ZERO, RST_ZERO, RST_ROW_LAST, RST_ZERO};
	localparam logic [REG_COUNT-1:0][7:0] REG_MASK = {
		MASK_GAIN, MASK_FULL, MASK_NIBBLE, MASK_FULL, MASK_LINE_HIGH, MASK_FULL, MASK_NIBBLE,
		MASK_LOW_BITS, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_NONE, MASK_FULL, MASK_FULL};

	// serial bus framing; device address value is arbitrary
	localparam logic [6:0] DEVICE_ADDR = 7'h2A;
	localparam logic [3:0] BYTE_BITS   = 4'h8;

endpackage

// ### design/pin_sync.sv
// two-flop synchroniser for asynchronous pin levels
// assumes pins idle at the reset value given by the parameter
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int             WIDTH     = 2,
	parameter logic [WIDTH-1:0] IDLE_VAL = '1
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	input  wire logic             i_ce,
	input  wire logic [WIDTH-1:0] i_d,
	output var  logic [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta <= IDLE_VAL;
			o_q  <= IDLE_VAL;
		end else if (i_ce) begin
			meta <= i_d;
			o_q  <= meta;
		end
	end
endmodule
`default_nettype wire

// ### design/sensor_window_timing_regs.sv
// readout window and exposure timing register bank with two-wire serial slave
// assumes scl and sda arrive asynchronously; sda is open drain, driven low only
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - scan first row used plus one when increment flag set, raw otherwise.
// - scan last row resets FB; plus one when increment flag set.
// - increment flag is low-bits bit 6, reset cleared, cleared means raw rows.
// - view first row is eight-bit part plus low-bits bit 0, reset 0.
// - view last row resets FB, low bit from low-bits bit 1, reset 1.
// - view first column adds two low bits from low-bits bits 3:2, reset 0.
// - view last column resets A5, low bits from bits 5:4, reset 3.
// - low-bits register resets to 32 hex; bit 7 has no function.
// - exposure is 12-bit row lead, four high bits and eight low.
// - line gap is 11 bits, three high bits in low positions.
// - frame gap is 12 bits, high nibble in low nibble of register.
// - gain is six bits, 00 is 0 dB, 3F is 15 dB.
// - all bank registers read and write; reset values as listed.
module sensor_window_timing_regs (
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_ce,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output var  logic        o_sda_out,
	output var  logic        o_sda_oe_n,
	output var  logic [8:0]  o_scan_first_row,
	output var  logic [8:0]  o_scan_last_row,
	output var  logic [8:0]  o_view_first_row,
	output var  logic [8:0]  o_view_last_row,
	output var  logic [9:0]  o_view_first_col,
	output var  logic [9:0]  o_view_last_col,
	output var  logic [11:0] o_exposure_rows,
	output var  logic [10:0] o_line_gap,
	output var  logic [11:0] o_frame_gap,
	output var  logic [5:0]  o_amplifier_gain_code
);
	typedef enum logic [3:0] {
		st_idle, st_addr, st_addr_ack, st_ptr, st_ptr_ack,
		st_wdata, st_wdata_ack, st_rdata, st_rdata_ack
	} state_t;

	state_t      state;
	logic [1:0]  pins_s;
	logic        scl_s;
	logic        sda_s;
	logic        scl_prev;
	logic        sda_prev;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_seen;
	logic        stop_seen;
	logic [3:0]  cnt;
	logic [7:0]  shift;
	logic [7:0]  ptr;
	logic        rw;
	logic        drive_low;
	logic        read_nack;
	logic        wr_en;
	logic [7:0]  rd_data;
	logic [7:0]  regs [0:sensor_regs_pkg::REG_COUNT-1];
	logic        incr;

	// true where an offset names a register of this bank
	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a >= sensor_regs_pkg::ADDR_SCAN_ROW_FIRST) &&
			(a <= sensor_regs_pkg::ADDR_AMPLIFIER_GAIN) && (a != sensor_regs_pkg::ADDR_HOLE);
	endfunction

	// bank index from a byte offset
	function automatic logic [3:0] reg_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - sensor_regs_pkg::ADDR_SCAN_ROW_FIRST;
		reg_idx = d[3:0];
	endfunction

	// pins pass two flops before any decode
	pin_sync #(
		.WIDTH    (2),
		.IDLE_VAL (2'h3)
	) u_pin_sync (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.i_d       ({i_scl, i_sda}),
		.o_q       (pins_s)
	);
	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// previous synchronised levels for edge detection
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else if (i_ce) begin
			scl_prev <= scl_s;
			sda_prev <= sda_s;
		end
	end

	// bus conditions; sda moving while scl high frames a transfer
	assign scl_rise   = scl_s && !scl_prev;
	assign scl_fall   = !scl_s && scl_prev;
	assign start_seen = scl_s && scl_prev && sda_prev && !sda_s;
	assign stop_seen  = scl_s && scl_prev && !sda_prev && sda_s;

	// open drain: data is always low, the enable decides
	assign o_sda_out  = 1'b0;
	assign o_sda_oe_n = !drive_low;

	// register write strobe at the end of a data byte
	assign wr_en = i_ce && (state == st_wdata) && scl_fall && (cnt == sensor_regs_pkg::BYTE_BITS) &&
		reg_hit(ptr);

	// read mux; unmapped offsets read zero
	always_comb begin
		rd_data = 8'h00;
		if (reg_hit(ptr)) begin
			rd_data = regs[reg_idx(ptr)];
		end
	end

	// serial protocol engine; start and stop override any state
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state     <= st_idle;
			cnt       <= 4'h0;
			shift     <= 8'h00;
			ptr       <= 8'h00;
			rw        <= 1'b0;
			drive_low <= 1'b0;
			read_nack <= 1'b0;
		end else if (i_ce) begin
			if (start_seen) begin
				state     <= st_addr;
				cnt       <= 4'h0;
				drive_low <= 1'b0;
			end else if (stop_seen) begin
				state     <= st_idle;
				drive_low <= 1'b0;
			end else begin
				unique case (state)
					st_idle: begin
						cnt <= 4'h0;
					end
					st_addr, st_ptr, st_wdata: begin
						if (scl_rise) begin
							shift <= {shift[6:0], sda_s};
							cnt   <= cnt + 4'h1;
						end else if (scl_fall && cnt == sensor_regs_pkg::BYTE_BITS) begin
							drive_low <= 1'b1;
							if (state == st_addr) begin
								// a foreign address drops off the bus silently
								if (shift[7:1] == sensor_regs_pkg::DEVICE_ADDR) begin
									rw    <= shift[0];
									state <= st_addr_ack;
								end else begin
									drive_low <= 1'b0;
									state     <= st_idle;
								end
							end else if (state == st_ptr) begin
								ptr   <= shift;
								state <= st_ptr_ack;
							end else begin
								ptr   <= ptr + 8'h01;
								state <= st_wdata_ack;
							end
						end
					end
					st_addr_ack: begin
						if (scl_fall) begin
							cnt <= 4'h0;
							if (rw) begin
								shift     <= rd_data;
								drive_low <= !rd_data[7];
								state     <= st_rdata;
							end else begin
								drive_low <= 1'b0;
								state     <= st_ptr;
							end
						end
					end
					st_ptr_ack, st_wdata_ack: begin
						if (scl_fall) begin
							cnt       <= 4'h0;
							drive_low <= 1'b0;
							state     <= st_wdata;
						end
					end
					st_rdata: begin
						if (scl_rise) begin
							cnt <= cnt + 4'h1;
						end else if (scl_fall) begin
							if (cnt == sensor_regs_pkg::BYTE_BITS) begin
								drive_low <= 1'b0;
								ptr       <= ptr + 8'h01;
								state     <= st_rdata_ack;
							end else begin
								drive_low <= !shift[6];
								shift     <= {shift[6:0], 1'b0};
							end
						end
					end
					st_rdata_ack: begin
						if (scl_rise) begin
							read_nack <= sda_s;
						end else if (scl_fall) begin
							cnt <= 4'h0;
							// master nack ends the burst
							if (read_nack) begin
								state <= st_idle;
							end else begin
								shift     <= rd_data;
								drive_low <= !rd_data[7];
								state     <= st_rdata;
							end
						end
					end
				endcase
			end
		end
	end

	// register bank; masked write keeps reserved bits at zero
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < sensor_regs_pkg::REG_COUNT; i++) begin
				regs[i] <= sensor_regs_pkg::REG_RESET[i];
			end
		end else if (wr_en) begin
			regs[reg_idx(ptr)] <= shift & sensor_regs_pkg::REG_MASK[reg_idx(ptr)];
		end
	end

	assign incr = regs[sensor_regs_pkg::IDX_LOW_BITS][sensor_regs_pkg::BIT_SCAN_INCR];

	// values for the timing engine, one flop after the bank
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_scan_first_row      <= 9'h000;
			o_scan_last_row       <= 9'h000;
			o_view_first_row      <= 9'h000;
			o_view_last_row       <= 9'h000;
			o_view_first_col      <= 10'h000;
			o_view_last_col       <= 10'h000;
			o_exposure_rows       <= 12'h000;
			o_line_gap            <= 11'h000;
			o_frame_gap           <= 12'h000;
			o_amplifier_gain_code <= 6'h00;
		end else if (i_ce) begin
			o_scan_first_row <= {1'b0, regs[sensor_regs_pkg::IDX_SCAN_FIRST]} + {8'h00, incr};
			o_scan_last_row  <= {1'b0, regs[sensor_regs_pkg::IDX_SCAN_LAST]} + {8'h00, incr};
			o_view_first_row <= {regs[sensor_regs_pkg::IDX_VIEW_RFIRST],
				regs[sensor_regs_pkg::IDX_LOW_BITS][sensor_regs_pkg::BIT_VIEW_RFIRST_LSB]};
			o_view_last_row  <= {regs[sensor_regs_pkg::IDX_VIEW_RLAST],
				regs[sensor_regs_pkg::IDX_LOW_BITS][sensor_regs_pkg::BIT_VIEW_RLAST_LSB]};
			o_view_first_col <= {regs[sensor_regs_pkg::IDX_VIEW_CFIRST],
				regs[sensor_regs_pkg::IDX_LOW_BITS][sensor_regs_pkg::POS_VIEW_CFIRST_LSB +: 2]};
			o_view_last_col  <= {regs[sensor_regs_pkg::IDX_VIEW_CLAST],
				regs[sensor_regs_pkg::IDX_LOW_BITS][sensor_regs_pkg::POS_VIEW_CLAST_LSB +: 2]};
			o_exposure_rows  <= {regs[sensor_regs_pkg::IDX_EXPO_HIGH][3:0],
				regs[sensor_regs_pkg::IDX_EXPO_LOW]};
			o_line_gap       <= {regs[sensor_regs_pkg::IDX_LINE_HIGH][2:0],
				regs[sensor_regs_pkg::IDX_LINE_LOW]};
			o_frame_gap      <= {regs[sensor_regs_pkg::IDX_FRAME_HIGH][3:0],
				regs[sensor_regs_pkg::IDX_FRAME_LOW]};
			o_amplifier_gain_code <= regs[sensor_regs_pkg::IDX_GAIN][5:0];
		end
	end

	// checks on the bank and its outputs
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	sequence seq_own_addr;
		state == st_addr && i_ce && scl_fall && cnt == 4'h8 && shift[7:1] == 7'h2A;
	endsequence
	sequence seq_ack_driven;
		state == st_addr_ack && !o_sda_oe_n;
	endsequence

	a_scan_first_incr: assert property (
		i_ce && incr |=> o_scan_first_row == {1'b0, $past(regs[0])} + 9'h001)
		else $error("scan first row not incremented");
	a_scan_last_incr: assert property (
		i_ce && incr |=> o_scan_last_row == {1'b0, $past(regs[1])} + 9'h001)
		else $error("scan last row not incremented");
	a_scan_raw_clear: assert property (
		i_ce && !incr |=> o_scan_first_row == {1'b0, $past(regs[0])} &&
			o_scan_last_row == {1'b0, $past(regs[1])})
		else $error("scan rows altered with flag clear");
	a_view_row_first: assert property (
		i_ce |=> o_view_first_row == {$past(regs[3]), $past(regs[7][0])})
		else $error("view first row packing wrong");
	a_view_row_last: assert property (
		i_ce |=> o_view_last_row == {$past(regs[4]), $past(regs[7][1])})
		else $error("view last row packing wrong");
	a_view_col_first: assert property (
		i_ce |=> o_view_first_col == {$past(regs[5]), $past(regs[7][3:2])})
		else $error("view first column packing wrong");
	a_view_col_last: assert property (
		i_ce |=> o_view_last_col == {$past(regs[6]), $past(regs[7][5:4])})
		else $error("view last column packing wrong");
	a_low_bits_reset: assert property (
		$rose(i_reset_n) |-> regs[7] == 8'h32 && regs[1] == 8'hFB && regs[6] == 8'hA5)
		else $error("reset values wrong");
	a_exposure_pack: assert property (
		i_ce |=> o_exposure_rows == {$past(regs[8][3:0]), $past(regs[9])})
		else $error("exposure rows packing wrong");
	a_line_gap_pack: assert property (
		i_ce |=> o_line_gap == {$past(regs[10][2:0]), $past(regs[11])})
		else $error("line gap packing wrong");
	a_frame_gap_pack: assert property (
		i_ce |=> o_frame_gap == {$past(regs[12][3:0]), $past(regs[13])})
		else $error("frame gap packing wrong");
	a_gain_field: assert property (
		i_ce |=> o_amplifier_gain_code == $past(regs[14][5:0]))
		else $error("gain code wrong");
	a_write_lands: assert property (
		wr_en && ptr == 8'h0F |=> regs[4] == $past(shift))
		else $error("register write lost");
	a_reserved_zero: assert property (
		regs[7][7] == 1'b0 && regs[8][7:4] == 4'h0 && regs[10][7:3] == 5'h00 &&
		regs[12][7:4] == 4'h0 && regs[14][7:6] == 2'h0 && regs[2] == 8'h00)
		else $error("reserved bits not zero");
	a_addr_ack: assert property (
		seq_own_addr |=> seq_ack_driven)
		else $error("own address not acknowledged");

	// a foreign address must leave the wire alone, or two slaves would fight over it
	sequence seq_other_addr;
		state == st_addr && i_ce && scl_fall && cnt == 4'h8 && shift[7:1] != 7'h2A;
	endsequence
	a_foreign_quiet: assert property (
		seq_other_addr |=> state == st_idle && o_sda_oe_n)
		else $error("foreign address answered");

	// enable low freezes the bank, the engine and the outputs alike
	a_ce_freeze: assert property (
		!i_ce |=> $stable(regs[14]) && $stable(state) &&
			$stable(o_amplifier_gain_code) && $stable(o_sda_oe_n))
		else $error("state moved with enable low");
endmodule
`default_nettype wire

// ### verif/bus_host_model.sv
// two-wire bus host model: drives the serial clock and pulls the data wire low
// assumes the bench resolves the data wire with a pull-up and feeds it back
`timescale 1ns/10ps
`default_nettype none
module bus_host_model (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output var  logic o_scl,
	output var  logic o_sda_oe_n
);
	// bus idles released, clock high, so the slave sees no spurious start
	initial begin
		o_scl = 1'b1;
		o_sda_oe_n = 1'b1;
	end

	// all pin changes land on falling edges, away from the sampling edge
	task automatic gap(input int n);
		repeat (n) @(negedge i_clk);
	endtask

	// start or repeated start; half periods stay above the slave's sync delay
	task automatic bus_start();
		o_sda_oe_n = 1'b1;
		gap(4);
		o_scl = 1'b1;
		gap(8);
		o_sda_oe_n = 1'b0;
		gap(8);
		o_scl = 1'b0;
		gap(4);
	endtask

	task automatic bus_stop();
		o_sda_oe_n = 1'b0;
		gap(4);
		o_scl = 1'b1;
		gap(8);
		o_sda_oe_n = 1'b1;
		gap(8);
	endtask

	// eight bits msb first then the ninth; a 1 releases the wire for the slave
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			o_sda_oe_n = tx[i];
			gap(4);
			o_scl = 1'b1;
			gap(4);
			rx[i] = i_sda;
			gap(4);
			o_scl = 1'b0;
			gap(4);
		end
	endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the window and timing register bank
// assumes the bus host model; the data wire is pulled up when nobody drives it
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        i_clk     = 1'b0;
	logic        i_reset_n = 1'b0;
	logic        i_ce      = 1'b1;
	wire logic   scl;
	wire logic   host_oe_n;
	wire logic   sda;
	wire logic   dev_out;
	wire logic   dev_oe_n;
	wire logic [8:0]  sf;
	wire logic [8:0]  sl;
	wire logic [8:0]  vrf;
	wire logic [8:0]  vrl;
	wire logic [9:0]  vcf;
	wire logic [9:0]  vcl;
	wire logic [11:0] expo;
	wire logic [10:0] lgap;
	wire logic [11:0] fgap;
	wire logic [5:0]  gain;
	logic [7:0]  model [15];
	logic [8:0]  rx;
	int          err_total = 0;
	int          checks    = 0;
	int          seed      = 56;

	always #5 i_clk = ~i_clk;
	// open-drain wire: low if either side pulls
	assign sda = host_oe_n & (dev_oe_n | dev_out);

	sensor_window_timing_regs sensor_window_timing_regs_inst (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_scl(scl), .i_sda(sda),
		.o_sda_out(dev_out), .o_sda_oe_n(dev_oe_n), .o_scan_first_row(sf), .o_scan_last_row(sl),
		.o_view_first_row(vrf), .o_view_last_row(vrl), .o_view_first_col(vcf), .o_view_last_col(vcl),
		.o_exposure_rows(expo), .o_line_gap(lgap), .o_frame_gap(fgap), .o_amplifier_gain_code(gain));

	bus_host_model bus_host_model_inst (
		.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(host_oe_n));

	// expected output values worked out from the shadow copy of the bank
	function automatic logic [11:0] expect_out(input int k);
		logic [7:0] lb;
		lb = model[7];
		case (k)
			0: return 12'(model[0]) + 12'(lb[6]);
			1: return 12'(model[1]) + 12'(lb[6]);
			2: return 12'({model[3], lb[0]});
			3: return 12'({model[4], lb[1]});
			4: return 12'({model[5], lb[3:2]});
			5: return 12'({model[6], lb[5:4]});
			6: return {model[8][3:0], model[9]};
			7: return 12'({model[10][2:0], model[11]});
			8: return {model[12][3:0], model[13]};
			default: return 12'(model[14][5:0]);
		endcase
	endfunction

	task automatic check_val(input string what, input logic [11:0] exp, input logic [11:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_ack(input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected ack expected %b seen %b", exp, got);
		end
	endtask

	task automatic send(input logic [7:0] b, input logic ack_exp);
		bus_host_model_inst.xfer({b, 1'b1}, rx);
		check_ack(ack_exp, rx[0]);
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		bus_host_model_inst.bus_start();
		send({sensor_regs_pkg::DEVICE_ADDR, 1'b0}, 1'b0);
		send(a, 1'b0);
		send(d, 1'b0);
		bus_host_model_inst.bus_stop();
	endtask

	// offset write, repeated start, one byte read, host nack ends it
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		bus_host_model_inst.bus_start();
		send({sensor_regs_pkg::DEVICE_ADDR, 1'b0}, 1'b0);
		send(a, 1'b0);
		bus_host_model_inst.bus_start();
		send({sensor_regs_pkg::DEVICE_ADDR, 1'b1}, 1'b0);
		bus_host_model_inst.xfer(9'h1FF, rx);
		d = rx[8:1];
		bus_host_model_inst.bus_stop();
	endtask

	// write by bank index and keep the shadow copy, reserved bits dropped
	task automatic put(input int i, input logic [7:0] d);
		reg_write(sensor_regs_pkg::ADDR_SCAN_ROW_FIRST + 8'(i), d);
		if (i != 2) begin
			model[i] = d & sensor_regs_pkg::REG_MASK[i];
		end
	endtask

	task automatic read_one(input int i);
		logic [7:0] d;
		reg_read(sensor_regs_pkg::ADDR_SCAN_ROW_FIRST + 8'(i), d);
		check_val("readback", 12'(model[i]), 12'(d));
	endtask

	task automatic check_outs();
		check_val("scan_first", expect_out(0), 12'(sf));
		check_val("scan_last", expect_out(1), 12'(sl));
		check_val("view_first_row", expect_out(2), 12'(vrf));
		check_val("view_last_row", expect_out(3), 12'(vrl));
		check_val("view_first_col", expect_out(4), 12'(vcf));
		check_val("view_last_col", expect_out(5), 12'(vcl));
		check_val("exposure", expect_out(6), expo);
		check_val("line_gap", expect_out(7), 12'(lgap));
		check_val("frame_gap", expect_out(8), fgap);
		check_val("gain", expect_out(9), 12'(gain));
	endtask

	task automatic check_reads();
		for (int i = 0; i < 15; i++) begin
			read_one(i);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// main sequence: reset values, corners, refusals, random rounds, second reset
	initial begin
		logic [7:0] d;
		for (int i = 0; i < 15; i++) model[i] = sensor_regs_pkg::REG_RESET[i];
		repeat (16) @(negedge i_clk);
		i_reset_n = 1'b1;
		repeat (4) @(negedge i_clk);
		check_outs();
		check_reads();
		// every low bit plus reserved bit 7, row values at their top
		put(7, 8'hFF);
		put(0, 8'hFF);
		put(1, 8'hFF);
		put(10, 8'hFF);
		put(12, 8'hFF);
		put(8, 8'hFF);
		put(14, 8'hFF);
		check_outs();
		read_one(7);
		read_one(10);
		read_one(14);
		// reserved bit alone: flag cleared, rows back to raw values
		put(7, 8'h80);
		check_outs();
		read_one(7);
		// unmapped offsets take a write but read as zero
		reg_write(8'h0D, 8'hA5);
		reg_write(8'h20, 8'h5A);
		reg_read(8'h20, d);
		check_val("unmapped", 12'h000, 12'(d));
		// foreign device address is not acknowledged
		bus_host_model_inst.bus_start();
		send({sensor_regs_pkg::DEVICE_ADDR ^ 7'h01, 1'b0}, 1'b1);
		bus_host_model_inst.bus_stop();
		// enable low: a whole write goes unseen and the bank keeps its values
		i_ce = 1'b0;
		bus_host_model_inst.bus_start();
		send({sensor_regs_pkg::DEVICE_ADDR, 1'b0}, 1'b1);
		send(sensor_regs_pkg::ADDR_AMPLIFIER_GAIN, 1'b1);
		send(8'h2C, 1'b1);
		bus_host_model_inst.bus_stop();
		i_ce = 1'b1;
		repeat (4) @(negedge i_clk);
		check_outs();
		read_one(14);
		repeat (2) begin
			for (int i = 0; i < 15; i++) put(i, 8'($random(seed)));
			check_outs();
			check_reads();
		end
		// reset in mid-run restores every default
		i_reset_n = 1'b0;
		repeat (3) @(negedge i_clk);
		i_reset_n = 1'b1;
		for (int i = 0; i < 15; i++) model[i] = sensor_regs_pkg::REG_RESET[i];
		repeat (4) @(negedge i_clk);
		check_outs();
		read_one(7);
		read_one(6);
		print_verdict();
	end

	// watchdog cuts a hung run short
	initial begin
		repeat (100000) @(posedge i_clk);
		err_total++;
		print_verdict();
	end
endmodule
`default_nettype wire
